// ==== common/u9s_pkg.sv ====
// constants, types and field layouts for the 9-bit serial transceiver
// Summary of operation
// - receive fifo 16 by 12 bits, transmit fifo 16 by 9 bits
// - character length of five to eight data bits, both directions
// - parity even, odd, stuck or none, generated and checked
// - transmitter sends one or two stop bits as configured
// - baud rate programmable from zero to clock over sixteen
// - start, stop, parity added on send and stripped on receive
// - line break can be driven and received breaks are flagged
// - infrared encoder and decoder selectable in both paths
// - break control holds line low; clearing resumes normal framing
// - busy stays set until fifo empty and last stop bit sent
// - 9-bit address compared after masking; mask all ones selects one
// - address sent after queued data drains, marked as address
// - 9-bit data uses the normal fifo paths; received data is kept only after an address match
// - receive fifo non-empty indication is exposed
package u9s_pkg;
	// ************************************************************
	// field positions and widths
	// ************************************************************
	localparam int DATA_W     = 8;
	localparam int RX_ENTRY_W = 12;
	localparam int FIFO_DEPTH = 16;
	localparam int OVS        = 16;
	localparam int ST_FRAME   = 8;
	localparam int ST_PARITY  = 9;
	localparam int ST_BREAK   = 10;
	localparam int ST_OVERRUN = 11;
	localparam logic [3:0] OVS_LAST = 4'hF;
	localparam logic [3:0] OVS_MID  = 4'h7;
	localparam logic [3:0] IR_PULSE = 4'h2; // 3/16 of a bit

	// ************************************************************
	// modes and frame layout
	// ************************************************************
	typedef enum logic [2:0] {
		U9S_PAR_NONE = 3'h0,
		U9S_PAR_EVEN = 3'h1,
		U9S_PAR_ODD  = 3'h2,
		U9S_PAR_ONE  = 3'h3,
		U9S_PAR_ZERO = 3'h4
	} u9s_par_t;

	typedef struct packed {
		logic [1:0] char_len;  // 0..3 means 5..8 bits
		u9s_par_t   parity;
		logic       two_stop;
		logic       nine_bit;
		logic       infrared_line_coding;
	} u9s_cfg_t;

	typedef enum logic [2:0] {
		U9S_IDLE   = 3'h0,
		U9S_START  = 3'h1,
		U9S_DATA   = 3'h3,
		U9S_PARITY = 3'h2,
		U9S_STOP   = 3'h6
	} u9s_state_t;
endpackage

// ==== src/u9s_uart.sv ====
// 9-bit capable asynchronous serial transceiver with fifos
`timescale 1ns/100ps
module u9s_uart #(
	parameter int DEPTH  = u9s_pkg::FIFO_DEPTH,
	parameter int DIV_W  = 16
) (
	input  wire logic                         core_clk,
	input  wire logic                         rst_b,
	input  wire u9s_pkg::u9s_cfg_t            cfg,
	input  wire logic [DIV_W-1:0]             baud_div,
	input  wire logic                         break_request,
	input  wire logic [7:0]                   own_node_address,
	input  wire logic [7:0]                   address_match_mask,
	input  wire logic                         tx_valid,
	input  wire logic [7:0]                   tx_data,
	input  wire logic                         tx_is_addr,
	output logic                              tx_ready,
	output logic                              rx_avail,
	input  wire logic                         rx_read,
	output logic [u9s_pkg::RX_ENTRY_W-1:0]    rx_entry,
	output logic                              tx_busy,
	output logic                              addr_match,
	output logic                              ser_out,
	input  wire logic                         ser_in
);
	localparam int PW = $clog2(DEPTH);

	// pointer wrap needs a power of two depth
	if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
		$error("depth must be a power of two");
	end

	// ************************************************************
	// helpers
	// ************************************************************
	function automatic logic par_bit(input logic [8:0] d,
		input u9s_pkg::u9s_par_t m);
		logic p;
		p = ^d;
		unique case (m)
			u9s_pkg::U9S_PAR_ODD:  par_bit = ~p;
			u9s_pkg::U9S_PAR_ONE:  par_bit = 1'b1;
			u9s_pkg::U9S_PAR_ZERO: par_bit = 1'b0;
			default:               par_bit = p;
		endcase
	endfunction

	function automatic logic [3:0] nbits(input u9s_pkg::u9s_cfg_t c);
		nbits = 4'(c.char_len) + 4'h5 + (c.nine_bit ? 4'h1 : 4'h0);
	endfunction

	// ************************************************************
	// baud tick at sixteen times the bit rate
	// ************************************************************
	logic [DIV_W-1:0] bcnt_q, bcnt_d;
	logic             tick;
	always_comb begin
		tick   = (baud_div != '0) && (bcnt_q == '0);
		bcnt_d = tick ? baud_div - 1'b1 :
			(baud_div == '0 ? '0 : bcnt_q - 1'b1);
	end
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b)
			bcnt_q <= '0;
		else
			bcnt_q <= bcnt_d;
	end

	// ************************************************************
	// fifos: tx 9 bits (addr mark + data), rx 12 bits
	// ************************************************************
	logic [8:0]                   txm [DEPTH];
	logic [u9s_pkg::RX_ENTRY_W-1:0] rxm [DEPTH];
	logic [PW:0] twp_q, twp_d, trp_q, trp_d, rwp_q, rwp_d, rrp_q, rrp_d;
	logic        tx_empty, rx_full, tx_pop, rx_push;
	logic [u9s_pkg::RX_ENTRY_W-1:0] rx_new;
	logic        addr_pending;

	always_comb begin
		tx_empty = (twp_q == trp_q);
		rx_full  = (rwp_q - rrp_q) == (PW+1)'(DEPTH);
		rx_avail = (rwp_q != rrp_q);
		// address waits for the fifo to drain
		tx_ready = ((twp_q - trp_q) != (PW+1)'(DEPTH)) &&
			!(tx_is_addr && (!tx_empty || tx_busy));
		twp_d = twp_q + (PW+1)'(tx_valid && tx_ready);
		trp_d = trp_q + (PW+1)'(tx_pop);
		rwp_d = rwp_q + (PW+1)'(rx_push && !rx_full);
		rrp_d = rrp_q + (PW+1)'(rx_read && rx_avail);
		rx_entry = rxm[rrp_q[PW-1:0]];
		addr_pending = 1'b0;
	end
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			twp_q <= '0;
			trp_q <= '0;
			rwp_q <= '0;
			rrp_q <= '0;
		end else begin
			twp_q <= twp_d;
			trp_q <= trp_d;
			rwp_q <= rwp_d;
			rrp_q <= rrp_d;
		end
	end
	// memory writes; data arrays hold no reset
	always_ff @(posedge core_clk) begin
		if (tx_valid && tx_ready)
			txm[twp_q[PW-1:0]] <= {tx_is_addr, tx_data};
		if (rx_push && !rx_full)
			rxm[rwp_q[PW-1:0]] <= rx_new;
	end

	// ************************************************************
	// transmitter
	// ************************************************************
	u9s_pkg::u9s_state_t ts_q, ts_d;
	logic [3:0] tov_q, tov_d, tbit_q, tbit_d;
	logic [8:0] tsh_q, tsh_d;
	logic       tpar_q, tpar_d, tline_q, tline_d, tbusy_q, tbusy_d;
	logic       tstop2_q, tstop2_d;
	logic [8:0] tword, dmask;

	always_comb begin
		// only the configured data bits go out and into parity
		dmask = ~(9'h1FF << (4'(cfg.char_len) + 4'h5));
		tword = txm[trp_q[PW-1:0]];
		ts_d = ts_q;
		tov_d = tov_q;
		tbit_d = tbit_q;
		tsh_d = tsh_q;
		tpar_d = tpar_q;
		tline_d = tline_q;
		tstop2_d = tstop2_q;
		tx_pop = 1'b0;
		unique case (ts_q)
			u9s_pkg::U9S_IDLE: begin
				tline_d = 1'b1;
				if (!tx_empty && !break_request && tick) begin
					tx_pop = 1'b1;
					// ninth bit marks an address character
					tsh_d = ({1'b0, tword[7:0]} & dmask) |
						(9'(cfg.nine_bit && tword[8]) <<
						(4'(cfg.char_len) + 4'h5));
					tpar_d = par_bit(tsh_d, cfg.parity);
					ts_d = u9s_pkg::U9S_START;
					tov_d = '0;
					tline_d = 1'b0;
				end
			end
			u9s_pkg::U9S_START: if (tick) begin
				tov_d = tov_q + 4'h1;
				if (tov_q == u9s_pkg::OVS_LAST) begin
					ts_d = u9s_pkg::U9S_DATA;
					tbit_d = '0;
					tline_d = tsh_q[0];
				end
			end
			u9s_pkg::U9S_DATA: if (tick) begin
				tov_d = tov_q + 4'h1;
				if (tov_q == u9s_pkg::OVS_LAST) begin
					tbit_d = tbit_q + 4'h1;
					tsh_d = {1'b0, tsh_q[8:1]};
					tline_d = tsh_q[1];
					if (tbit_q == nbits(cfg) - 4'h1) begin
						ts_d = (cfg.parity == u9s_pkg::U9S_PAR_NONE) ?
							u9s_pkg::U9S_STOP : u9s_pkg::U9S_PARITY;
						tline_d = (cfg.parity == u9s_pkg::U9S_PAR_NONE)
							? 1'b1 : tpar_q;
						tstop2_d = cfg.two_stop;
					end
				end
			end
			u9s_pkg::U9S_PARITY: if (tick) begin
				tov_d = tov_q + 4'h1;
				if (tov_q == u9s_pkg::OVS_LAST) begin
					ts_d = u9s_pkg::U9S_STOP;
					tline_d = 1'b1;
				end
			end
			u9s_pkg::U9S_STOP: if (tick) begin
				tov_d = tov_q + 4'h1;
				if (tov_q == u9s_pkg::OVS_LAST) begin
					tstop2_d = 1'b0;
					if (!tstop2_q)
						ts_d = u9s_pkg::U9S_IDLE;
				end
			end
			default: ts_d = u9s_pkg::U9S_IDLE;
		endcase
		// busy until fifo empty and last stop bit gone
		tbusy_d = !tx_empty || (ts_d != u9s_pkg::U9S_IDLE);
	end
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			ts_q <= u9s_pkg::U9S_IDLE;
			tov_q <= '0;
			tbit_q <= '0;
			tsh_q <= '0;
			tpar_q <= 1'b0;
			tline_q <= 1'b1;
			tbusy_q <= 1'b0;
			tstop2_q <= 1'b0;
		end else begin
			ts_q <= ts_d;
			tov_q <= tov_d;
			tbit_q <= tbit_d;
			tsh_q <= tsh_d;
			tpar_q <= tpar_d;
			tline_q <= tline_d;
			tbusy_q <= tbusy_d;
			tstop2_q <= tstop2_d;
		end
	end

	// ************************************************************
	// line output: break and infrared encoder
	// ************************************************************
	logic sout_q, sout_d;
	always_comb begin
		if (break_request)
			sout_d = 1'b0;
		else if (cfg.infrared_line_coding)
			// a zero bit becomes a short high pulse
			sout_d = !tline_q && (tov_q <= u9s_pkg::IR_PULSE);
		else
			sout_d = tline_q;
	end
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b)
			sout_q <= 1'b1;
		else
			sout_q <= sout_d;
	end
	assign ser_out = sout_q;
	assign tx_busy = tbusy_q;

	// ************************************************************
	// receive input sync and infrared decoder
	// ************************************************************
	logic s1_q, s2_q, irh_q, irh_d, rin;
	logic [3:0] rov_q, rov_d;
	always_comb begin
		// stretch an ir pulse to a low level for one bit
		irh_d = s2_q ? 1'b1 : (tick && rov_q == u9s_pkg::OVS_LAST ?
			1'b0 : irh_q);
		rin = cfg.infrared_line_coding ? !(s2_q || irh_q) : s2_q;
	end
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			s1_q <= 1'b1;
			s2_q <= 1'b1;
			irh_q <= 1'b0;
		end else begin
			s1_q <= ser_in;
			s2_q <= s1_q;
			irh_q <= irh_d;
		end
	end

	// ************************************************************
	// receiver
	// ************************************************************
	u9s_pkg::u9s_state_t rs_q, rs_d;
	logic [3:0] rbit_q, rbit_d;
	logic [8:0] rsh_q, rsh_d;
	logic       rperr_q, rperr_d, rzero_q, rzero_d, ovr_q, ovr_d;
	logic       am_q, am_d;
	logic [8:0] rword;
	logic       frame_err, brk;

	always_comb begin
		rs_d = rs_q;
		rov_d = rov_q;
		rbit_d = rbit_q;
		rsh_d = rsh_q;
		rperr_d = rperr_q;
		rzero_d = rzero_q;
		rx_push = 1'b0;
		rword = rsh_q >> (4'h9 - nbits(cfg));
		frame_err = !rin;
		brk = rzero_q && !rin;
		rx_new = {ovr_q, brk, rperr_q, frame_err, rword[7:0]};
		am_d = am_q;
		unique case (rs_q)
			u9s_pkg::U9S_IDLE: if (tick && !rin) begin
				rs_d = u9s_pkg::U9S_START;
				rov_d = '0;
			end
			u9s_pkg::U9S_START: if (tick) begin
				rov_d = rov_q + 4'h1;
				if (rov_q == u9s_pkg::OVS_MID - 4'h1 && rin)
					rs_d = u9s_pkg::U9S_IDLE;
				else if (rov_q == u9s_pkg::OVS_LAST - 4'h1) begin
					rs_d = u9s_pkg::U9S_DATA;
					rbit_d = '0;
					rzero_d = 1'b1;
					rperr_d = 1'b0;
				end
			end
			u9s_pkg::U9S_DATA: if (tick) begin
				rov_d = rov_q + 4'h1;
				if (rov_q == u9s_pkg::OVS_MID) begin
					rsh_d = {rin, rsh_q[8:1]};
					rzero_d = rzero_q && !rin;
					rbit_d = rbit_q + 4'h1;
				end else if (rov_q == u9s_pkg::OVS_LAST &&
					rbit_q == nbits(cfg)) begin
					rs_d = (cfg.parity == u9s_pkg::U9S_PAR_NONE) ?
						u9s_pkg::U9S_STOP : u9s_pkg::U9S_PARITY;
				end
			end
			u9s_pkg::U9S_PARITY: if (tick) begin
				rov_d = rov_q + 4'h1;
				if (rov_q == u9s_pkg::OVS_MID) begin
					rperr_d = rin != par_bit(rword, cfg.parity);
					rzero_d = rzero_q && !rin;
				end else if (rov_q == u9s_pkg::OVS_LAST)
					rs_d = u9s_pkg::U9S_STOP;
			end
			u9s_pkg::U9S_STOP: if (tick) begin
				rov_d = rov_q + 4'h1;
				if (rov_q == u9s_pkg::OVS_MID) begin
					rs_d = u9s_pkg::U9S_IDLE;
					if (cfg.nine_bit && rword[8]) begin
						// masked address compare
						am_d = ((rword[7:0] & address_match_mask) ==
							(own_node_address & address_match_mask));
					end else
						rx_push = !cfg.nine_bit || am_q;
				end
			end
			default: rs_d = u9s_pkg::U9S_IDLE;
		endcase
		ovr_d = (ovr_q && !(rx_push && !rx_full)) || (rx_push && rx_full);
	end
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			rs_q <= u9s_pkg::U9S_IDLE;
			rov_q <= '0;
			rbit_q <= '0;
			rsh_q <= '0;
			rperr_q <= 1'b0;
			rzero_q <= 1'b0;
			ovr_q <= 1'b0;
			am_q <= 1'b0;
		end else begin
			rs_q <= rs_d;
			rov_q <= rov_d;
			rbit_q <= rbit_d;
			rsh_q <= rsh_d;
			rperr_q <= rperr_d;
			rzero_q <= rzero_d;
			ovr_q <= ovr_d;
			am_q <= am_d;
		end
	end
	assign addr_match = am_q;
endmodule

// ==== dv/u9s_uart_sva.sv ====
// port assertions for the serial transceiver
`timescale 1ns/100ps
module u9s_uart_sva (
	input wire logic                          core_clk,
	input wire logic                          rst_b,
	input wire u9s_pkg::u9s_cfg_t             cfg,
	input wire logic                          break_request,
	input wire logic                          tx_valid,
	input wire logic                          tx_is_addr,
	input wire logic                          tx_ready,
	input wire logic                          rx_avail,
	input wire logic                          rx_read,
	input wire logic [u9s_pkg::RX_ENTRY_W-1:0] rx_entry,
	input wire logic                          tx_busy,
	input wire logic                          ser_out
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_b);
	wire ir = cfg.infrared_line_coding;
	// *****
	// line and fifo relations
	// *****
	a_idle_mark:
	assert property (!tx_busy && !break_request && !$past(break_request)
		&& !ir && !$past(ir) |-> ser_out) else $error("idle line low");
	a_break_low:
	assert property (break_request |=> !ser_out) else $error("no break");
	a_busy_write:
	assert property (tx_valid && tx_ready |-> ##[1:2] tx_busy)
		else $error("busy missing");
	a_busy_end:
	assert property ($fell(tx_busy) && !ir |-> ser_out && $past(ser_out, 8))
		else $error("busy fell before stop end");
	a_addr_idle:
	assert property (tx_ready && tx_is_addr |-> !tx_busy)
		else $error("address taken while busy");
	a_idle_ready:
	assert property (!tx_busy && !tx_is_addr |-> tx_ready)
		else $error("idle but not ready");
	a_head_stable:
	assert property (rx_avail && !rx_read |=> rx_avail && $stable(rx_entry))
		else $error("head entry moved");
	a_ir_idle:
	assert property (ir && $past(ir) && !tx_busy && !break_request
		&& !$past(break_request) |-> !ser_out) else $error("ir idle high");
	// main scenarios seen
	cover property ($fell(tx_busy));
	cover property (rx_read && rx_avail && rx_entry[10]);
	cover property (break_request [*8]);
endmodule
bind u9s_uart u9s_uart_sva i_sva (
	.core_clk(core_clk), .rst_b(rst_b), .cfg(cfg),
	.break_request(break_request), .tx_valid(tx_valid),
	.tx_is_addr(tx_is_addr), .tx_ready(tx_ready), .rx_avail(rx_avail),
	.rx_read(rx_read), .rx_entry(rx_entry), .tx_busy(tx_busy),
	.ser_out(ser_out));

// ==== dv/u9s_remote.sv ====
// remote line partner: frame sender and frame catcher
`timescale 1ns/100ps
module u9s_remote #(
	parameter int BIT_NS = 128
) (
	input wire logic       ser_out,
	output logic           ser_in,
	input wire logic [3:0] nb
);
	logic [11:0] q[$];
	logic [11:0] r;
	// line idles at mark
	initial ser_in = 1'b1;
	// start bit then raw bits, lsb first
	task automatic snd(input logic [11:0] b, input logic [3:0] n);
		ser_in = 1'b0;
		#(BIT_NS);
		for (int i = 0; i < n; i++) begin
			ser_in = b[i];
			#(BIT_NS);
		end
		ser_in = 1'b1;
	endtask
	// catch raw bits at mid bit after a start edge
	always begin
		@(negedge ser_out);
		#(BIT_NS / 2);
		if (ser_out === 1'b0) begin
			r = 12'h000;
			for (int i = 0; i < nb; i++) begin
				#(BIT_NS);
				r[i] = ser_out;
			end
			q.push_back(r);
		end
	end
endmodule

// ==== dv/u9s_uart_tb.sv ====
// self-checking bench for the serial transceiver
`timescale 1ns/100ps
module u9s_uart_tb;
	localparam int BD = 2;
	logic              core_clk, rst_b, break_request, tx_valid;
	logic              tx_is_addr, rx_read, tx_ready, rx_avail;
	logic              tx_busy, addr_match, ser_out, ser_in;
	u9s_pkg::u9s_cfg_t cfg;
	logic [15:0]       baud_div;
	logic [7:0]        own_node_address, address_match_mask, tx_data, d;
	logic [11:0]       rx_entry, e;
	logic [3:0]        nbits;
	logic [11:0]       exp_q[$];
	int                err_total, cmp_count, nacc, pp;

	u9s_uart i_dut (.core_clk(core_clk), .rst_b(rst_b), .cfg(cfg),
		.baud_div(baud_div), .break_request(break_request),
		.own_node_address(own_node_address), .tx_busy(tx_busy),
		.address_match_mask(address_match_mask), .tx_valid(tx_valid),
		.tx_data(tx_data), .tx_is_addr(tx_is_addr), .tx_ready(tx_ready),
		.rx_avail(rx_avail), .rx_read(rx_read), .rx_entry(rx_entry),
		.addr_match(addr_match), .ser_out(ser_out), .ser_in(ser_in));
	u9s_remote #(.BIT_NS(BD * 64)) i_far (.ser_out(ser_out),
		.ser_in(ser_in), .nb(nbits));

	// clock and watchdog
	initial begin
		core_clk = 1'b0;
		forever #2 core_clk = ~core_clk;
	end
	initial begin
		#300000;
		err_total++;
		give_verdict();
	end

	task chk(input logic [11:0] s, input logic [11:0] x);
		cmp_count++;
		if (s !== x) begin
			err_total++;
			$display("ERROR t=%0t seen %h exp %h", $time, s, x);
		end
	endtask
	task give_verdict();
		$display("errors %0d compares %0d", err_total, cmp_count);
		if (err_total == 0 && cmp_count > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	// model of the raw bits after the start bit
	function automatic logic [11:0] fr(input logic [7:0] v, input logic a);
		int n;
		logic [11:0] r;
		logic p;
		n = cfg.char_len + 5;
		r = 12'(v) & ((12'h001 << n) - 12'h001);
		if (cfg.nine_bit) begin
			r[n] = a;
			n++;
		end
		p = ^r;
		pp = n;
		case (cfg.parity)
			u9s_pkg::U9S_PAR_EVEN: r[n] = p;
			u9s_pkg::U9S_PAR_ODD:  r[n] = ~p;
			u9s_pkg::U9S_PAR_ONE:  r[n] = 1'b1;
			u9s_pkg::U9S_PAR_ZERO: r[n] = 1'b0;
			default: n--;
		endcase
		n++;
		r[n] = 1'b1;
		r[n+1] = cfg.two_stop;
		nbits = 4'(n + 1 + cfg.two_stop);
		return r;
	endfunction
	task wr(input logic [7:0] v, input logic a);
		int g;
		tx_valid = 1'b1;
		tx_data = v;
		tx_is_addr = a;
		g = 0;
		while (tx_ready !== 1'b1 && g < 40) begin
			@(negedge core_clk);
			g++;
		end
		if (tx_ready === 1'b1)
			nacc++;
		@(negedge core_clk);
	endtask
	task get_tx();
		int g;
		g = 0;
		while (i_far.q.size() == 0 && g < 2000) begin
			@(negedge core_clk);
			g++;
		end
		chk(tx_busy, 12'h001);
		chk(i_far.q.pop_front(), exp_q.pop_front());
	endtask
	task tx_done();
		int g;
		g = 0;
		while (tx_busy !== 1'b0 && g < 9000) begin
			@(negedge core_clk);
			g++;
		end
	endtask
	task get_rx(input logic [11:0] x, input logic [11:0] m);
		int g;
		g = 0;
		do begin
			@(negedge core_clk);
			g++;
		end while (rx_avail !== 1'b1 && g < 2000);
		chk(rx_entry & m, x);
		rx_read = 1'b1;
		@(negedge core_clk);
		rx_read = 1'b0;
	endtask

	// main sequence
	initial begin
		cfg = '0;
		baud_div = 16'(BD);
		{break_request, tx_valid, tx_is_addr, rx_read, rst_b} = 5'h00;
		{own_node_address, address_match_mask, tx_data} = 24'h000000;
		err_total = 0;
		cmp_count = 0;
		nacc = 0;
		d = 8'($urandom(27913));
		repeat (6) @(negedge core_clk);
		rst_b = 1'b1;
		chk({ser_out, tx_busy, rx_avail, tx_ready}, 12'h009);
		// every length, parity and stop mode, both ways
		for (int i = 0; i < 10; i++) begin
			cfg.char_len = 2'(i);
			cfg.parity = u9s_pkg::u9s_par_t'(i % 5);
			cfg.two_stop = 1'(i / 5);
			repeat (2) begin
				d = 8'($urandom());
				exp_q.push_back(fr(d, 1'b0));
				wr(d, 1'b0);
			end
			tx_valid = 1'b0;
			repeat (2) get_tx();
			tx_done();
			d = 8'($urandom());
			e = fr(d, 1'b0);
			if (i == 4)
				e[pp] = ~e[pp];
			i_far.snd(e, nbits);
			get_rx({2'b00, i == 4, 1'b0, d & (8'hFF >> (3 - i % 4))},
				12'hFFF);
		end
		// break over two frames, then normal framing
		break_request = 1'b1;
		repeat (800) @(negedge core_clk);
		chk(ser_out, 12'h000);
		break_request = 1'b0;
		repeat (40) @(negedge core_clk);
		i_far.q.delete();
		cfg = '0;
		cfg.char_len = 2'h3;
		exp_q.push_back(fr(8'h5C, 1'b0));
		wr(8'h5C, 1'b0);
		tx_valid = 1'b0;
		get_tx();
		tx_done();
		i_far.snd(12'h000, nbits);
		get_rx(12'h500, 12'hDFF);
		// transmit fifo fills while the baud is stopped
		baud_div = '0;
		nacc = 0;
		for (int k = 0; k < 17; k++)
			wr(8'(k), 1'b0);
		tx_valid = 1'b0;
		chk({tx_ready, ser_out}, 12'h001);
		baud_div = 16'(BD);
		tx_done();
		repeat (40) @(negedge core_clk);
		chk(12'(i_far.q.size()), 12'(nacc));
		i_far.q.delete();
		// receive fifo overrun after sixteen unread characters
		for (int k = 0; k < 17; k++) begin
			d = 8'($urandom());
			if (k < 16)
				exp_q.push_back({4'h0, d});
			i_far.snd({4'h1, d}, nbits);
		end
		repeat (16) get_rx(exp_q.pop_front(), 12'hFFF);
		i_far.snd(12'h1A5, nbits);
		get_rx(12'h8A5, 12'hFFF);
		// nine-bit data, refused early address, then address
		cfg.nine_bit = 1'b1;
		exp_q.push_back(fr(8'h33, 1'b0));
		wr(8'h33, 1'b0);
		tx_valid = 1'b0;
		tx_is_addr = 1'b1;
		@(negedge core_clk);
		chk(tx_ready, 12'h000);
		get_tx();
		tx_done();
		exp_q.push_back(fr(8'hA5, 1'b1));
		wr(8'hA5, 1'b1);
		tx_valid = 1'b0;
		get_tx();
		tx_done();
		// address filter table: own, mask, sent
		for (int k = 0; k < 4; k++) begin
			own_node_address = 8'(32'h5A5A_5050 >> (24 - 8 * k));
			address_match_mask = 8'(32'hFFFF_F0F0 >> (24 - 8 * k));
			i_far.snd(fr(8'(32'h5B5A_5363 >> (24 - 8 * k)), 1'b1), nbits);
			repeat (40) @(negedge core_clk);
			chk(addr_match, k == 1 || k == 2);
			d = 8'($urandom());
			i_far.snd(fr(d, 1'b0), nbits);
			if (k == 1 || k == 2)
				get_rx({4'h0, d}, 12'hFFF);
			else begin
				repeat (40) @(negedge core_clk);
				chk(rx_avail, 12'h000);
			end
		end
		// infrared coding idles low
		cfg = '0;
		cfg.infrared_line_coding = 1'b1;
		repeat (20) @(negedge core_clk);
		chk(ser_out, 12'h000);
		give_verdict();
	end
endmodule
